// ### hw/flash_dev.sv
/*
 flash device end: opcode decoder, chip erase, quad mode, power-down,
 id reads and program/erase suspend and resume.
 assumes link pins are asynchronous to clk_i and are synchronised here.
*/
`include "flash_ctrl_map.svh"
module flash_dev #(
	parameter int ERASE_CYCLES = `ERASE_CYCLES,
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary
	parameter logic [7:0] TYPE_ID = 8'h40, // arbitrary
	parameter logic [7:0] CAP_ID = 8'h1c, // arbitrary
	parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 // arbitrary
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link
	flash_link_if.dev link,
	// status
	input wire logic [2:0] block_protect_bits_i,
	output logic write_in_progress_o,
	output logic write_enable_latch_o,
	output logic [1:0] suspend_status_bits_o,
	output logic quad_command_mode_o,
	output logic deep_power_down_o
);
	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic [2:0] cs_s_q, ck_s_q;
	logic [3:0] dq_s1_q, dq_s2_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_s_q <= 3'h7;
			ck_s_q <= 3'h0;
			dq_s1_q <= 4'h0;
			dq_s2_q <= 4'h0;
		end else begin
			cs_s_q <= {cs_s_q[1:0], link.cs_n};
			ck_s_q <= {ck_s_q[1:0], link.sclk};
			dq_s1_q <= link.dq;
			dq_s2_q <= dq_s1_q;
		end
	end
	wire sel = !cs_s_q[1];
	wire cs_rise = cs_s_q[1] && !cs_s_q[2];
	wire ck_rise = sel && ck_s_q[1] && !ck_s_q[2];
	wire ck_fall = sel && !ck_s_q[1] && ck_s_q[2];
	// ----------------------------------------
	// opcode shift
	// ----------------------------------------
	logic [7:0] sh_q, op_q;
	logic [8:0] nbits_q;
	logic quad_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_q <= 8'h00;
			nbits_q <= 9'h000;
		end else if (!sel) begin
			nbits_q <= 9'h000;
		end else if (ck_rise) begin
			sh_q <= quad_q ? {sh_q[3:0], dq_s2_q} : {sh_q[6:0], dq_s2_q[0]};
			nbits_q <= nbits_q + (quad_q ? 9'h004 : 9'h001);
		end
	end
	wire op_done = (nbits_q == 9'h008);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) op_q <= 8'h00;
		else if (ck_rise && nbits_q == (quad_q ? 9'h004 : 9'h007)) op_q <= quad_q ? {sh_q[3:0], dq_s2_q} : {sh_q[6:0], dq_s2_q[0]};
	end
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic wip_q, wel_q, pd_q, rst_en_q;
	logic [1:0] sus_q;
	flash_ctrl_pkg::op_kind_e kind_q;
	logic [31:0] cnt_q, pd_cnt_q;
	logic pd_entering_q, pd_exiting_q;
	wire busy = wip_q;
	wire blocked = pd_q || pd_entering_q || pd_exiting_q;
	wire whole_op = cs_rise && op_done;
	// program and sector erase end on a byte boundary after the address
	wire addr_op = cs_rise && nbits_q >= 9'h020 && nbits_q[2:0] == 3'h0;
	function automatic logic is_op(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b);
		is_op = (o == a) || (o == b);
	endfunction : is_op
	wire prog_sus = sus_q[0];
	wire erase_sus = sus_q[1];
	wire write_reject = (|sus_q) && (is_op(op_q, `OP_WRITE_REG, `OP_WRITE_CFG) || op_q == `OP_SEC_ERASE
		|| is_op(op_q, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B) || op_q == `OP_SECTOR_ERASE
		|| (prog_sus && (op_q == `OP_SEC_PROG || op_q == `OP_PAGE_PROG)));
	wire can_start = whole_op && !blocked && !busy && !write_reject;
	wire can_start_addr = addr_op && !blocked && !busy && !write_reject;
	// quad mode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) quad_q <= 1'b0;
		else if (whole_op && !blocked && !quad_q && op_q == `OP_QUAD_ENTER) quad_q <= 1'b1;
		else if (whole_op && !blocked && quad_q && op_q == `OP_QUAD_EXIT) quad_q <= 1'b0;
	end
	// write latch, busy, erase/program cycles, suspend
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wel_q <= 1'b0;
			wip_q <= 1'b0;
			sus_q <= 2'h0;
			kind_q <= flash_ctrl_pkg::op_none;
			cnt_q <= 32'h0;
		end else begin
			if (wip_q && cnt_q != 32'h0) begin
				cnt_q <= cnt_q - 32'h1;
				if (cnt_q == 32'h2) wel_q <= 1'b0;
				if (cnt_q == 32'h1) begin
					wip_q <= 1'b0;
					if (|sus_q == 1'b0) kind_q <= flash_ctrl_pkg::op_none;
				end
			end
			if (can_start && op_q == `OP_WRITE_EN) wel_q <= 1'b1;
			if (can_start && is_op(op_q, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B) && wel_q
					&& block_protect_bits_i == 3'h0) begin
				wip_q <= 1'b1;
				// whole-array erase is not a pausable kind
				kind_q <= flash_ctrl_pkg::op_none;
				cnt_q <= 32'(ERASE_CYCLES);
			end
			if (can_start_addr && (op_q == `OP_PAGE_PROG || op_q == `OP_SECTOR_ERASE) && wel_q
					&& block_protect_bits_i == 3'h0) begin
				wip_q <= 1'b1;
				kind_q <= op_q == `OP_PAGE_PROG ? flash_ctrl_pkg::op_program : flash_ctrl_pkg::op_erase;
				cnt_q <= 32'(ERASE_CYCLES);
			end
			if (whole_op && !blocked && op_q == `OP_PAUSE && wip_q && sus_q == 2'h0
					&& kind_q != flash_ctrl_pkg::op_none) begin
				sus_q <= (kind_q == flash_ctrl_pkg::op_program) ? 2'h1 : 2'h2;
				cnt_q <= `PAUSE_CYCLES;
			end
			if (whole_op && !blocked && op_q == `OP_CONTINUE && |sus_q && !wip_q) begin
				sus_q <= 2'h0;
				wip_q <= 1'b1;
				cnt_q <= 32'(ERASE_CYCLES);
			end
		end
	end
	// deep power-down
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_q <= 1'b0;
			pd_entering_q <= 1'b0;
			pd_exiting_q <= 1'b0;
			rst_en_q <= 1'b0;
			pd_cnt_q <= 32'h0;
		end else begin
			if (pd_entering_q || pd_exiting_q) begin
				pd_cnt_q <= pd_cnt_q - 32'h1;
				if (pd_cnt_q == 32'h1) begin
					pd_q <= pd_entering_q;
					pd_entering_q <= 1'b0;
					pd_exiting_q <= 1'b0;
				end
			end
			if (whole_op && !blocked && !busy && op_q == `OP_POWER_DOWN) begin
				pd_entering_q <= 1'b1;
				pd_cnt_q <= `ENTRY_CYCLES;
			end
			if (whole_op && pd_q) begin
				rst_en_q <= (op_q == `OP_RESET_EN);
				if (op_q == `OP_RELEASE && !busy) begin
					pd_exiting_q <= 1'b1;
					pd_cnt_q <= `EXIT_CYCLES;
				end
				if (op_q == `OP_RESET && rst_en_q) pd_q <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// id and unique number output
	// ----------------------------------------
	logic [127:0] out_q;
	logic out_en_q;
	logic [8:0] out_start_q;
	wire is_ident = is_op(op_q, `OP_IDENT_A, `OP_IDENT_B);
	wire is_uid = op_q == `OP_UNIQUE_ID;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_q <= 128'h0;
			out_en_q <= 1'b0;
			out_start_q <= 9'h000;
		end else if (!sel) begin
			out_en_q <= 1'b0;
		end else if (ck_fall && op_done && !out_en_q && !blocked && !busy
				&& (is_ident || is_uid)) begin
			out_en_q <= 1'b1;
			out_start_q <= is_uid ? (quad_q ? 9'h028 : 9'h028) : 9'h008;
			out_q <= is_uid ? UNIQUE_ID : {MAKER_ID, TYPE_ID, CAP_ID, 104'h0};
		end else if (ck_fall && out_en_q && nbits_q > out_start_q) begin
			out_q <= {out_q[126:0], 1'b0};
		end
	end
	wire drive = out_en_q && sel && nbits_q >= out_start_q;
	assign link.dev_dq = {2'h0, out_q[127], 1'b0};
	assign link.dev_dq_oe_n = {2'h3, !drive, 1'b1};
	assign write_in_progress_o = wip_q;
	assign write_enable_latch_o = wel_q;
	assign suspend_status_bits_o = sus_q;
	assign quad_command_mode_o = quad_q;
	assign deep_power_down_o = pd_q;
endmodule : flash_dev

// ### hw/flash_ctrl_map.svh
/*
 opcodes and timing counts for the flash command block.
 assumes inclusion by bare name from both ends and the bench.
*/
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_QUAD_ENTER 8'h38
`define OP_QUAD_EXIT 8'hff
`define OP_POWER_DOWN 8'hb9
`define OP_RELEASE 8'hab
`define OP_RESET_EN 8'h66
`define OP_RESET 8'h99
`define OP_UNIQUE_ID 8'h4b
`define OP_IDENT_A 8'h9f
`define OP_IDENT_B 8'h9e
`define OP_PAUSE 8'h75
`define OP_CONTINUE 8'h7a
`define OP_WRITE_EN 8'h06
`define OP_PAGE_PROG 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_WRITE_REG 8'h01
`define OP_WRITE_CFG 8'hb1
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define CLK_PERIOD_NS 5
`define RESUME_TIME_NS 200
`define RESUME_CYCLES (`RESUME_TIME_NS / `CLK_PERIOD_NS)
`define PAUSE_CYCLES 16
`define ENTRY_CYCLES 64
`define EXIT_CYCLES 64
`define EXIT_MARGIN 8
`define ERASE_CYCLES 8192
`define HOST_DIV 16
`endif

// ### hw/flash_ctrl_pkg.sv
/*
 shared types for the flash command block.
 assumes flash_ctrl_map.svh on the include path.
*/
package flash_ctrl_pkg;
	typedef enum logic [1:0] {
		op_none,
		op_program,
		op_erase
	} op_kind_e;
endpackage : flash_ctrl_pkg

// ### hw/flash_link_if.sv
/*
 serial flash link: chip select, serial clock and four data lines.
 assumes the bench resolves the data wires from the enables (low = driving).
*/
interface flash_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_dq;
	logic [3:0] host_dq_oe_n;
	logic [3:0] dev_dq;
	logic [3:0] dev_dq_oe_n;
	logic [3:0] dq;
	modport host (output cs_n, output sclk, output host_dq, output host_dq_oe_n, input dq);
	modport dev (input cs_n, input sclk, output dev_dq, output dev_dq_oe_n, input dq);
endinterface : flash_link_if

// ### hw/flash_host.sv
/*
 host end: issues one command frame per request and returns read bytes.
 assumes the device end samples the link with its own clock.
*/
`include "flash_ctrl_map.svh"
module flash_host #(
	parameter int DIV = `HOST_DIV,
	parameter int EXIT_WAIT = `EXIT_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link
	flash_link_if.host link,
	// request
	input wire logic req_i,
	input wire logic [7:0] opcode_i,
	input wire logic [5:0] tail_bytes_i,
	input wire logic [4:0] read_bytes_i,
	input wire logic quad_i,
	output logic ready_o,
	output logic done_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o
);
	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	typedef enum {st_idle, st_shift, st_gap} st_e;
	st_e st_q;
	logic [7:0] op_q, rd_sh_q;
	logic [8:0] bit_q, total_q, out_start_q;
	logic [7:0] div_q;
	logic quad_q, ck_q;
	logic [31:0] gap_q;
	logic [2:0] dq_s1_q, dq_s2_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dq_s1_q <= 3'h0;
			dq_s2_q <= 3'h0;
		end else begin
			dq_s1_q <= {link.dq[1], 2'h0};
			dq_s2_q <= dq_s1_q;
		end
	end
	wire half = (div_q == 8'(DIV / 2 - 1));
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= st_idle;
			op_q <= 8'h00;
			bit_q <= 9'h000;
			total_q <= 9'h000;
			out_start_q <= 9'h000;
			div_q <= 8'h00;
			quad_q <= 1'b0;
			ck_q <= 1'b0;
			gap_q <= 32'h0;
			rd_sh_q <= 8'h00;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			done_o <= 1'b0;
			case (st_q)
				st_idle: if (req_i) begin
					op_q <= opcode_i;
					quad_q <= quad_i;
					out_start_q <= 9'h008 + {tail_bytes_i, 3'h0};
					total_q <= 9'h008 + {tail_bytes_i, 3'h0} + {1'b0, read_bytes_i, 3'h0};
					bit_q <= 9'h000;
					div_q <= 8'h00;
					st_q <= st_shift;
				end
				st_shift: begin
					div_q <= half ? 8'h00 : div_q + 8'h01;
					if (half) begin
						ck_q <= !ck_q;
						if (ck_q) begin
							bit_q <= bit_q + ((quad_q && bit_q < 9'h008) ? 9'h004 : 9'h001);
							if (bit_q >= 9'h008 && bit_q[2:0] == 3'h7 && bit_q >= out_start_q) begin
								rd_valid_o <= 1'b1;
								rd_data_o <= rd_sh_q;
							end
						end else if (bit_q >= out_start_q) begin
							rd_sh_q <= {rd_sh_q[6:0], dq_s2_q[2]};
						end
						if (ck_q && bit_q + ((quad_q && bit_q < 9'h008) ? 9'h004 : 9'h001) >= total_q) begin
							st_q <= st_gap;
							gap_q <= (op_q == `OP_RELEASE) ? 32'(EXIT_WAIT + `EXIT_MARGIN) : 32'h4;
						end
					end
				end
				st_gap: begin
					gap_q <= gap_q - 32'h1;
					if (gap_q == 32'h1) begin
						st_q <= st_idle;
						done_o <= 1'b1;
					end
				end
				default: st_q <= st_idle;
			endcase
		end
	end
	// opcode bits msb first, then address/dummy: zero in serial mode, op_q[0] on dq[0] in quad mode
	wire [8:0] idx = bit_q;
	wire [3:0] nib = (idx < 9'h004) ? op_q[7:4] : op_q[3:0];
	wire ser = (idx < 9'h008) ? op_q[3'(7 - idx[2:0])] : 1'b0;
	assign link.cs_n = (st_q != st_shift);
	assign link.sclk = ck_q;
	assign link.host_dq = quad_q ? nib : {3'h0, ser};
	assign link.host_dq_oe_n = (st_q != st_shift) ? 4'hf
		: (quad_q && bit_q < 9'h008) ? 4'h0 : 4'he;
	assign ready_o = (st_q == st_idle);
endmodule : flash_host

// ### sim/flash_mode_power_suspend_ctrl_sva.sv
/*
 checker for the flash link and the device status outputs.
 assumes the bench instantiates it beside the link that joins host and device.
*/
module flash_mode_power_suspend_ctrl_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] dev_dq,
	input wire logic [3:0] dev_dq_oe_n,
	// status
	input wire logic write_in_progress_o,
	input wire logic write_enable_latch_o,
	input wire logic [1:0] suspend_status_bits_o,
	input wire logic quad_command_mode_o,
	input wire logic deep_power_down_o
);
	localparam int PAUSE_MAX = 17;
	localparam int RESUME_MAX = 40;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_idle_release;
		cs_n [*8] |-> dev_dq_oe_n == 4'hf;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("output driven while deselected");
	property p_fall_shift;
		!cs_n && dev_dq_oe_n != 4'hf && $changed(dev_dq) |-> !sclk;
	endproperty
	a_fall_shift: assert property (p_fall_shift) else $error("output moved with clock high");
	property p_mode_keep;
		$changed(quad_command_mode_o) |->
			$stable(write_enable_latch_o) && $stable(suspend_status_bits_o);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode switch changed status");
	property p_pause_drop;
		$rose(|suspend_status_bits_o) |-> ##[0:PAUSE_MAX] !write_in_progress_o;
	endproperty
	a_pause_drop: assert property (p_pause_drop) else $error("busy not dropped after pause");
	property p_pause_needs;
		$rose(|suspend_status_bits_o) |-> $past(write_in_progress_o);
	endproperty
	a_pause_needs: assert property (p_pause_needs) else $error("pause taken while idle");
	property p_resume_busy;
		$fell(|suspend_status_bits_o) |-> ##[0:RESUME_MAX] write_in_progress_o;
	endproperty
	a_resume_busy: assert property (p_resume_busy) else $error("busy late after resume");
	property p_entry;
		$rose(deep_power_down_o) |-> cs_n && $past(cs_n, 60);
	endproperty
	a_entry: assert property (p_entry) else $error("power-down entered early");
	property p_entry_idle;
		$rose(deep_power_down_o) |-> !write_in_progress_o;
	endproperty
	a_entry_idle: assert property (p_entry_idle) else $error("power-down during busy cycle");
	property p_asleep;
		deep_power_down_o && $past(deep_power_down_o) |-> $stable(quad_command_mode_o)
			&& $stable(write_enable_latch_o) && $stable(suspend_status_bits_o);
	endproperty
	a_asleep: assert property (p_asleep) else $error("command acted in power-down");
	property p_erase_end;
		$fell(write_in_progress_o) && suspend_status_bits_o == 2'h0 |-> !write_enable_latch_o;
	endproperty
	a_erase_end: assert property (p_erase_end) else $error("latch still set at cycle end");
	property p_exit_hold;
		$fell(deep_power_down_o) |-> $past(cs_n, 60);
	endproperty
	a_exit_hold: assert property (p_exit_hold) else $error("select low during exit delay");
endmodule : flash_mode_power_suspend_ctrl_sva

// ### sim/flash_mode_power_suspend_ctrl_bench.sv
/*
 bench: host end against one device end, and a bit-level driver on a second device end.
 assumes the hw files and flash_ctrl_map.svh are compiled first.
*/
`include "flash_ctrl_map.svh"
module flash_mode_power_suspend_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MK = 8'h3c; // arbitrary
	localparam logic [7:0] TY = 8'h21; // arbitrary
	localparam logic [7:0] CP = 8'h17; // arbitrary
	localparam logic [127:0] UID = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0; // arbitrary
	logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, quad_i = 1'b0, fl_q = 1'b0, qb = 1'b0;
	logic [7:0] opcode_i = 8'h00;
	logic [5:0] tail_bytes_i = 6'h00;
	logic [4:0] read_bytes_i = 5'h00;
	logic [2:0] bp_i = 3'h0;
	logic ready_o, done_o, rd_valid_o, write_in_progress, write_enable_latch, qm, dpd, wip_b, dpd_b;
	logic [1:0] sus;
	logic [7:0] rd_data_o, ce [2], id [2];
	logic [127:0] acc;
	logic [7:0] rxq [$];
	int bad_count = 0, num_checks = 0;
	flash_link_if lk ();
	flash_link_if lb ();
	assign lk.dq = (~lk.host_dq_oe_n & lk.host_dq) | (~lk.dev_dq_oe_n & lk.dev_dq)
		| (lk.host_dq_oe_n & lk.dev_dq_oe_n & {4{fl_q}});
	assign lb.dq = (~lb.host_dq_oe_n & lb.host_dq) | (~lb.dev_dq_oe_n & lb.dev_dq)
		| (lb.host_dq_oe_n & lb.dev_dq_oe_n & {4{fl_q}});
	flash_host #(.DIV(16), .EXIT_WAIT(64)) u_flash_host (.clk_i, .rst_i, .link(lk.host), .req_i,
		.opcode_i, .tail_bytes_i, .read_bytes_i, .quad_i, .ready_o, .done_o, .rd_data_o, .rd_valid_o);
	flash_dev #(.ERASE_CYCLES(4096), .MAKER_ID(MK), .TYPE_ID(TY), .CAP_ID(CP), .UNIQUE_ID(UID))
		u_flash_dev (.clk_i, .rst_i, .link(lk.dev), .block_protect_bits_i(bp_i),
		.write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .suspend_status_bits_o(sus),
		.quad_command_mode_o(qm), .deep_power_down_o(dpd));
	flash_dev #(.ERASE_CYCLES(4096)) u_flash_dev_b (.clk_i, .rst_i, .link(lb.dev),
		.block_protect_bits_i(3'h0), .write_in_progress_o(wip_b), .write_enable_latch_o(),
		.suspend_status_bits_o(), .quad_command_mode_o(), .deep_power_down_o(dpd_b));
	flash_mode_power_suspend_ctrl_sva u_flash_mode_power_suspend_ctrl_sva (.clk_i, .rst_i,
		.cs_n(lk.cs_n), .sclk(lk.sclk), .dev_dq(lk.dev_dq), .dev_dq_oe_n(lk.dev_dq_oe_n),
		.write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .suspend_status_bits_o(sus),
		.quad_command_mode_o(qm), .deep_power_down_o(dpd));
	// ----------------------------------------
	// clock, floating lines, read capture
	// ----------------------------------------
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) fl_q <= ~fl_q;
	always @(negedge clk_i) if (rd_valid_o === 1'b1) rxq.push_back(rd_data_o);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task cmd(input logic [7:0] op, input logic [5:0] tl, input logic [4:0] rb);
		int n;
		rxq = {};
		for (n = 0; n < 3000 && ready_o !== 1'b1; n++) @(negedge clk_i);
		if (ready_o !== 1'b1) bad_count++;
		@(posedge clk_i);
		req_i <= 1'b1;
		opcode_i <= op;
		tail_bytes_i <= tl;
		read_bytes_i <= rb;
		quad_i <= qb;
		@(posedge clk_i);
		req_i <= 1'b0;
		for (n = 0; n < 20000 && done_o !== 1'b1; n++) @(negedge clk_i);
		if (done_o !== 1'b1) bad_count++;
		repeat (4) @(negedge clk_i);
	endtask : cmd
	task wt;
		int n;
		for (n = 0; n < 9000 && write_in_progress !== 1'b0; n++) @(negedge clk_i);
		if (write_in_progress !== 1'b0) bad_count++;
	endtask : wt
	task bb(input logic [15:0] v, input int nb);
		int i;
		@(posedge clk_i);
		lb.cs_n <= 1'b0;
		lb.host_dq_oe_n <= 4'he;
		for (i = 0; i < nb; i++) begin
			lb.host_dq <= {3'h0, v[15-i]};
			repeat (16) @(posedge clk_i);
			lb.sclk <= 1'b1;
			repeat (16) @(posedge clk_i);
			lb.sclk <= 1'b0;
		end
		repeat (16) @(posedge clk_i);
		lb.cs_n <= 1'b1;
		lb.host_dq_oe_n <= 4'hf;
		repeat (80) @(negedge clk_i);
	endtask : bb
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#400us;
		bad_count++;
		wrap_up();
	end
	initial begin
		ce = '{`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B};
		id = '{`OP_IDENT_A, `OP_IDENT_B};
		lb.cs_n = 1'b1;
		lb.sclk = 1'b0;
		lb.host_dq = 4'h0;
		lb.host_dq_oe_n = 4'hf;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({write_in_progress, write_enable_latch, sus, qm, dpd}, 6'h00);
		for (int i = 0; i < 2; i++) begin
			cmd(ce[i], 0, 0);
			chk(write_in_progress, 1'b0);
			@(posedge clk_i) bp_i <= 3'h2;
			cmd(`OP_WRITE_EN, 0, 0);
			cmd(ce[i], 0, 0);
			chk(write_in_progress, 1'b0);
			@(posedge clk_i) bp_i <= 3'h0;
			cmd(ce[i], 0, 0);
			chk(write_in_progress, 1'b1);
			cmd(`OP_IDENT_A, 0, 1);
			chk(rxq[0] == MK, 1'b0);
			cmd(`OP_PAUSE, 0, 0);
			chk(sus, 2'h0);
			wt();
			chk({write_in_progress, write_enable_latch}, 2'h0);
		end
		cmd(`OP_WRITE_EN, 0, 0);
		cmd(`OP_QUAD_ENTER, 0, 0);
		qb = 1'b1;
		chk({qm, write_enable_latch}, 2'h3);
		cmd(`OP_QUAD_EXIT, 0, 0);
		qb = 1'b0;
		chk({qm, write_enable_latch}, 2'h1);
		cmd(`OP_IDENT_A, 0, 1);
		chk(rxq[0], MK);
		for (int i = 0; i < 2; i++) begin
			cmd(id[i], 0, 3);
			chk({rxq[0], rxq[1], rxq[2]}, {MK, TY, CP});
		end
		cmd(`OP_UNIQUE_ID, 4, 16);
		acc = '0;
		for (int i = 0; i < 16; i++) acc = {acc[119:0], rxq[i]};
		chk(acc, UID);
		cmd(`OP_PAUSE, 0, 0);
		chk(sus, 2'h0);
		cmd(`OP_CONTINUE, 0, 0);
		chk(write_in_progress, 1'b0);
		cmd(`OP_WRITE_EN, 0, 0);
		cmd(`OP_SECTOR_ERASE, 3, 0);
		cmd(`OP_PAUSE, 0, 0);
		chk(sus, 2'h2);
		repeat (20) @(negedge clk_i);
		chk(write_in_progress, 1'b0);
		cmd(`OP_WRITE_EN, 0, 0);
		cmd(`OP_CHIP_ERASE_A, 0, 0);
		chk(write_in_progress, 1'b0);
		cmd(`OP_CONTINUE, 0, 0);
		chk({sus, write_in_progress}, 3'h1);
		cmd(`OP_POWER_DOWN, 0, 0);
		repeat (80) @(negedge clk_i);
		chk({dpd, write_in_progress}, 2'h1);
		wt();
		cmd(`OP_WRITE_EN, 0, 0);
		cmd(`OP_PAGE_PROG, 4, 0);
		cmd(`OP_PAUSE, 0, 0);
		chk(sus, 2'h1);
		cmd(`OP_CONTINUE, 0, 0);
		wt();
		cmd(`OP_POWER_DOWN, 0, 0);
		repeat (80) @(negedge clk_i);
		chk(dpd, 1'b1);
		cmd(`OP_QUAD_ENTER, 0, 0);
		chk({dpd, qm}, 2'h2);
		cmd(`OP_RELEASE, 0, 0);
		chk(dpd, 1'b0);
		cmd(`OP_IDENT_A, 0, 1);
		chk(rxq[0], MK);
		bb({`OP_WRITE_EN, 8'h00}, 8);
		bb({`OP_CHIP_ERASE_A, 8'h00}, 12);
		chk(wip_b, 1'b0);
		bb({`OP_POWER_DOWN, 8'h00}, 11);
		chk(dpd_b, 1'b0);
		bb({`OP_POWER_DOWN, 8'h00}, 8);
		chk(dpd_b, 1'b1);
		bb({`OP_RESET_EN, 8'h00}, 8);
		bb({`OP_RESET, 8'h00}, 8);
		chk(dpd_b, 1'b0);
		wrap_up();
	end
endmodule : flash_mode_power_suspend_ctrl_bench
